/* src/tic_pkg.sv */
// shared constants and types of the time interval counter
// assumes a single 100 MHz clock and the processor's special function register bus
package tic_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int TIC_CLK_PERIOD_NS = 10;
  localparam int TIC_TICK_PERIOD_NS = 7812500;
  localparam int TIC_TICK_CYCLES = TIC_TICK_PERIOD_NS / TIC_CLK_PERIOD_NS;
  localparam int TIC_TICK_W = 20;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] TIC_A_CTRL = 8'hA1;
  localparam logic [7:0] TIC_A_SUB = 8'hA2;
  localparam logic [7:0] TIC_A_SEC = 8'hA3;
  localparam logic [7:0] TIC_A_MIN = 8'hA4;
  localparam logic [7:0] TIC_A_HOUR = 8'hA5;
  localparam logic [7:0] TIC_A_MATCH = 8'hA6;

  // ************************************************************
  // timer_control_reg fields and reset values
  // ************************************************************
  localparam int TIC_B_CEN = 0;
  localparam int TIC_B_IVEN = 1;
  localparam int TIC_B_HIT = 2;
  localparam int TIC_B_SEL_LO = 4;
  localparam int TIC_B_SEL_HI = 5;
  localparam int TIC_B_H24 = 6;
  localparam logic [7:0] TIC_CTRL_RST = 8'h00;
  localparam logic [7:0] TIC_CNT_RST = 8'h00;
  localparam logic [7:0] TIC_MATCH_RST = 8'h00;

  // ************************************************************
  // counter limits
  // ************************************************************
  localparam logic [7:0] TIC_SUB_MAX = 8'h7F;
  localparam logic [7:0] TIC_SEC_MAX = 8'h3B;
  localparam logic [7:0] TIC_MIN_MAX = 8'h3B;
  localparam logic [7:0] TIC_HOUR_MAX = 8'h17;

  typedef enum logic [1:0] {
    TIC_UNIT_SUB = 2'b00,
    TIC_UNIT_SEC = 2'b01,
    TIC_UNIT_MIN = 2'b10,
    TIC_UNIT_HOUR = 2'b11
  } tic_unit_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tic_sfr_req_t;

  typedef struct packed {
    logic [7:0] val;
  } tic_cnt_t;

  typedef struct packed {
    logic [TIC_TICK_W-1:0] div_cnt;
    logic [7:0] ctrl;
    logic [7:0] match_val;
    logic [7:0] ivl_cnt;
    logic [7:0] rdata;
  } tic_state_t;

endpackage

/* src/tic_wrap_cnt.sv */
// one wrapping time counter with software load
// assumes load and increment come from logic on the same clock
module tic_wrap_cnt #(
  parameter logic [7:0] MAX = 8'h3B
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic inc_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  output logic [7:0] val_o,
  output logic wrap_o
);
  import tic_pkg::*;

  tic_cnt_t cnt_r;
  tic_cnt_t cnt_nxt;

  // carry out when the counter passes its top value
  assign wrap_o = inc_i && !load_i && (cnt_r.val >= MAX);
  assign val_o = cnt_r.val;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt.val = load_val_i;
    end else if (inc_i) begin
      cnt_nxt.val = (cnt_r.val >= MAX) ? TIC_CNT_RST : 8'(cnt_r.val + 8'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_r <= '{val: TIC_CNT_RST};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

/* src/tic_top.sv */
// time-of-day and interval counter reached over the register bus
// assumes a 100 MHz clock and a synchronous active-low reset
//
// Summary of operation
// - while counting is enabled, advance sub-second counter every 1/128 second
// - sub-second counter runs 0..127, wraps and advances seconds
// - seconds counter runs 0..59, wraps and advances minutes
// - minutes counter runs 0..59, wraps and advances hours
// - hours counter runs 0..23 then wraps, nothing further advanced
// - interval counter equal to match value sets hit flag and interrupt request
// - match value register accepts any value 0..255
// - two unit-select bits pick interval unit: 1/128 s, s, min, h
// - control write 0D0H selects seconds idle, 0D3H also starts counting
module tic_top #(
  parameter int TICK_CYCLES = tic_pkg::TIC_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input tic_pkg::tic_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  output logic tic_irq_o
);
  import tic_pkg::*;

  tic_state_t st_r;
  tic_state_t st_nxt;

  logic tick;
  logic unit_tick;
  logic ival_hit;
  logic [7:0] ivl_inc;
  logic ld_sub;
  logic ld_sec;
  logic ld_min;
  logic ld_hour;
  logic ld_ctrl;
  logic ld_match;
  logic [7:0] sub_val;
  logic [7:0] sec_val;
  logic [7:0] min_val;
  logic [7:0] hour_val;
  logic sub_wrap;
  logic sec_wrap;
  logic min_wrap;
  logic count_en;
  logic ival_en;
  tic_unit_t unit_sel;

  // ************************************************************
  // decode
  // ************************************************************
  assign ld_ctrl = sfr_req_i.wr && (sfr_req_i.addr == TIC_A_CTRL);
  assign ld_sub = sfr_req_i.wr && (sfr_req_i.addr == TIC_A_SUB);
  assign ld_sec = sfr_req_i.wr && (sfr_req_i.addr == TIC_A_SEC);
  assign ld_min = sfr_req_i.wr && (sfr_req_i.addr == TIC_A_MIN);
  assign ld_hour = sfr_req_i.wr && (sfr_req_i.addr == TIC_A_HOUR);
  assign ld_match = sfr_req_i.wr && (sfr_req_i.addr == TIC_A_MATCH);

  assign count_en = st_r.ctrl[TIC_B_CEN];
  assign ival_en = st_r.ctrl[TIC_B_IVEN];
  assign unit_sel = tic_unit_t'({st_r.ctrl[TIC_B_SEL_HI], st_r.ctrl[TIC_B_SEL_LO]});

  // ************************************************************
  // 1/128 second tick
  // ************************************************************
  assign tick = count_en && (st_r.div_cnt == TIC_TICK_W'(TICK_CYCLES - 1));

  // ************************************************************
  // time cascade
  // ************************************************************
  tic_wrap_cnt #(.MAX(TIC_SUB_MAX)) u_sub (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .inc_i(tick),
    .load_i(ld_sub),
    .load_val_i(sfr_req_i.wdata),
    .val_o(sub_val),
    .wrap_o(sub_wrap)
  );

  tic_wrap_cnt #(.MAX(TIC_SEC_MAX)) u_sec (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .inc_i(sub_wrap),
    .load_i(ld_sec),
    .load_val_i(sfr_req_i.wdata),
    .val_o(sec_val),
    .wrap_o(sec_wrap)
  );

  tic_wrap_cnt #(.MAX(TIC_MIN_MAX)) u_min (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .inc_i(sec_wrap),
    .load_i(ld_min),
    .load_val_i(sfr_req_i.wdata),
    .val_o(min_val),
    .wrap_o(min_wrap)
  );

  // hour carry drives nothing further
  tic_wrap_cnt #(.MAX(TIC_HOUR_MAX)) u_hour (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .inc_i(min_wrap),
    .load_i(ld_hour),
    .load_val_i(sfr_req_i.wdata),
    .val_o(hour_val),
    .wrap_o()
  );

  // ************************************************************
  // interval counter
  // ************************************************************
  always_comb begin
    case (unit_sel)
      TIC_UNIT_SUB: unit_tick = tick;
      TIC_UNIT_SEC: unit_tick = sub_wrap;
      TIC_UNIT_MIN: unit_tick = sec_wrap;
      TIC_UNIT_HOUR: unit_tick = min_wrap;
      default: unit_tick = 1'b0;
    endcase
  end

  assign ivl_inc = 8'(st_r.ivl_cnt + 8'h01);
  assign ival_hit = ival_en && unit_tick && (ivl_inc == st_r.match_val);

  // ************************************************************
  // state update
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    if (!count_en || tick) begin
      st_nxt.div_cnt = '0;
    end else begin
      st_nxt.div_cnt = TIC_TICK_W'(st_r.div_cnt + 1'b1);
    end
    if (!ival_en) begin
      st_nxt.ivl_cnt = TIC_CNT_RST;
    end else if (ival_hit) begin
      st_nxt.ivl_cnt = TIC_CNT_RST;
    end else if (unit_tick) begin
      st_nxt.ivl_cnt = ivl_inc;
    end
    if (ld_ctrl) begin
      st_nxt.ctrl = sfr_req_i.wdata;
    end
    // a hit in the clearing cycle keeps the flag set
    st_nxt.ctrl[TIC_B_HIT] = st_nxt.ctrl[TIC_B_HIT] | ival_hit;
    if (ld_match) begin
      st_nxt.match_val = sfr_req_i.wdata;
    end
    if (sfr_req_i.rd) begin
      case (sfr_req_i.addr)
        TIC_A_CTRL: st_nxt.rdata = st_r.ctrl;
        TIC_A_SUB: st_nxt.rdata = sub_val;
        TIC_A_SEC: st_nxt.rdata = sec_val;
        TIC_A_MIN: st_nxt.rdata = min_val;
        TIC_A_HOUR: st_nxt.rdata = hour_val;
        TIC_A_MATCH: st_nxt.rdata = st_r.match_val;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= '{div_cnt: '0, ctrl: TIC_CTRL_RST, match_val: TIC_MATCH_RST, ivl_cnt: TIC_CNT_RST, rdata: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_o = st_r.rdata;
  assign tic_irq_o = st_r.ctrl[TIC_B_HIT];

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  no_count_idle_a: assert property (!count_en |-> !tick ##1 !tick)
    else $error("tick while counting disabled");
  sub_step_a: assert property (tick && !ld_sub |=>
    sub_val == (($past(sub_val) >= TIC_SUB_MAX) ? 8'h00 : 8'($past(sub_val) + 8'h01)))
    else $error("sub-second counter did not step on tick");
  sub_carry_a: assert property (sub_wrap && !ld_sec && sec_val < TIC_SEC_MAX |=>
    sub_val == 8'h00 && sec_val == 8'($past(sec_val) + 8'h01))
    else $error("seconds not advanced on sub-second wrap");
  sec_carry_a: assert property (sec_wrap && !ld_min && min_val < TIC_MIN_MAX |=>
    sec_val == 8'h00 && min_val == 8'($past(min_val) + 8'h01))
    else $error("minutes not advanced on seconds wrap");
  min_carry_a: assert property (min_wrap && !ld_hour && hour_val < TIC_HOUR_MAX |=>
    min_val == 8'h00 && hour_val == 8'($past(hour_val) + 8'h01))
    else $error("hours not advanced on minutes wrap");
  hour_wrap_a: assert property (min_wrap && !ld_hour && hour_val == TIC_HOUR_MAX |=> hour_val == 8'h00)
    else $error("hours did not wrap after 23");
  hit_flag_a: assert property (ival_hit |=> tic_irq_o && st_r.ctrl[TIC_B_HIT])
    else $error("interval hit not flagged");
  match_load_a: assert property (ld_match |=> st_r.match_val == $past(sfr_req_i.wdata))
    else $error("match value not stored");
  unit_sec_a: assert property (ival_en && unit_sel == TIC_UNIT_SEC && sub_wrap && !ival_hit && !ld_ctrl |=>
    st_r.ivl_cnt == 8'($past(st_r.ivl_cnt) + 8'h01))
    else $error("interval counter missed a seconds tick");
  ctrl_start_a: assert property (ld_ctrl && sfr_req_i.wdata == 8'hD3 |=>
    count_en && ival_en && unit_sel == TIC_UNIT_SEC)
    else $error("control write 0D3H did not start counting");
  ivl_clear_a: assert property (ival_hit && !ld_ctrl |=> st_r.ivl_cnt == 8'h00 ##1 st_r.ivl_cnt <= 8'h01)
    else $error("interval counter not cleared on match");
  flag_clear_a: assert property (ld_ctrl && !sfr_req_i.wdata[TIC_B_HIT] && !ival_hit |=> !tic_irq_o)
    else $error("hit flag not cleared by control write");
  div_step_a: assert property (count_en && !tick |=> st_r.div_cnt == TIC_TICK_W'($past(st_r.div_cnt) + 1'b1))
    else $error("tick divider did not step");

  hit_seen_c: cover property (ival_hit ##1 tic_irq_o);
  hour_roll_c: cover property (min_wrap && hour_val == TIC_HOUR_MAX);
  start_c: cover property (ld_ctrl && sfr_req_i.wdata == 8'hD3);
  sub_roll_c: cover property (sub_wrap);
  clear_race_c: cover property (ival_hit && ld_ctrl);

endmodule

/* test/tic_top_tb.sv */
// self-checking bench for the time interval counter top
// assumes tic_top with a shortened tick divider, driven over its register strobes
module tic_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tic_pkg::*;

  localparam int TCYC = 4;

  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  tic_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic irq;
  int n_fail = 0;
  int n_tests = 0;

  tic_top #(.TICK_CYCLES(TCYC)) tic_top_i (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sfr_req_i(req),
    .sfr_rdata_o(rdata),
    .tic_irq_o(irq)
  );

  always #5 clk_i = ~clk_i;

  // ************************************************************
  // bus tasks and compare
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_i);
    #1;
    req = '0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_i);
    #1;
    req = '0;
    d = rdata;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // watchdog
  // ************************************************************
  initial begin
    wait_cyc(40000);
    n_fail++;
    end_of_test();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    logic [7:0] v;
    logic [7:0] ctl;
    wait_cyc(3);
    rstn_i = 1'b1;
    // reset values and unmapped place
    for (int a = 8'hA1; a <= 8'hA6; a++) begin
      rd(8'(a), v);
      chk(v, 8'h00);
    end
    wr(8'hA0, 8'h55);
    rd(8'hA0, v);
    chk(v, 8'h00);
    rd(8'hA7, v);
    chk(v, 8'h00);
    wr(TIC_A_MATCH, 8'hFF);
    rd(TIC_A_MATCH, v);
    chk(v, 8'hFF);
    // preset time, nothing moves while counting is off
    wr(TIC_A_SUB, 8'h7E);
    wr(TIC_A_SEC, 8'h3B);
    wr(TIC_A_MIN, 8'h3B);
    wr(TIC_A_HOUR, 8'h17);
    wait_cyc(20);
    rd(TIC_A_SUB, v);
    chk(v, 8'h7E);
    // three ticks roll the whole day over
    wr(TIC_A_CTRL, 8'h01);
    wait_cyc(12);
    wr(TIC_A_CTRL, 8'h00);
    rd(TIC_A_SUB, v);
    chk(v, 8'h01);
    rd(TIC_A_SEC, v);
    chk(v, 8'h00);
    rd(TIC_A_MIN, v);
    chk(v, 8'h00);
    rd(TIC_A_HOUR, v);
    chk(v, 8'h00);
    // every interval unit, hit on the second sub tick
    for (int u = 0; u < 4; u++) begin
      ctl = 8'hC3 | 8'(u << 4);
      wr(TIC_A_CTRL, 8'h00);
      wr(TIC_A_SUB, 8'h7E);
      wr(TIC_A_SEC, 8'h3B);
      wr(TIC_A_MIN, 8'h3B);
      wr(TIC_A_HOUR, 8'h00);
      wr(TIC_A_MATCH, (u == 0) ? 8'h02 : 8'h01);
      wr(TIC_A_CTRL, ctl);
      wait_cyc(4);
      chk({7'h00, irq}, 8'h00);
      wait_cyc(6);
      chk({7'h00, irq}, 8'h01);
      rd(TIC_A_CTRL, v);
      chk(v, ctl | 8'h04);
      rd(TIC_A_HOUR, v);
      chk(v, 8'h01);
    end
    wr(TIC_A_CTRL, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // twenty second interval, then the next one without reload
    wr(TIC_A_CTRL, 8'hD0);
    rd(TIC_A_CTRL, v);
    chk(v, 8'hD0);
    wr(TIC_A_SUB, 8'h00);
    wr(TIC_A_MATCH, 8'h14);
    wr(TIC_A_CTRL, 8'hD3);
    wait_cyc(20 * 128 * TCYC - 8);
    chk({7'h00, irq}, 8'h00);
    wait_cyc(16);
    chk({7'h00, irq}, 8'h01);
    wr(TIC_A_CTRL, 8'hD3);
    chk({7'h00, irq}, 8'h00);
    wait_cyc(20 * 128 * TCYC - 40);
    chk({7'h00, irq}, 8'h00);
    wait_cyc(60);
    chk({7'h00, irq}, 8'h01);
    end_of_test();
  end
endmodule
